/* File: src/spd_cfg.svh */
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH

// select byte device type codes
`define SPD_MEM_CODE    4'hA
`define SPD_PROT_CODE   4'h6

// erased byte and top of the 256-byte array
`define SPD_ERASED      8'hFF
`define SPD_TOP_ADDR    8'hFF
`define SPD_ADDR_ONE    8'h01
`define SPD_PAGE_ONE    4'h1

// bit positions
`define SPD_RW_BIT      0
`define SPD_HALF_BIT    7
`define SPD_LAST_BIT    3'h7

// write buffer shape
`define SPD_FIFO_WIDTH  16
`define SPD_FIFO_DEPTH  16

`endif

/* File: src/spd_pkg.sv */
`default_nettype none
package spd_pkg;

    // serial protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } spd_state_type;

    // one buffered write: location and value
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } spd_wr_type;

endpackage
`default_nettype wire

/* File: src/spd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module spd_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // released bus lines idle high
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= '1;
            q      <= '1;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* File: src/spd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module spd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             full;
    logic             empty;

    assign empty     = (wr_ptr_q == rd_ptr_q);
    assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = store_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (in_valid && !full) begin
            store_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
        end else if (in_valid && !full) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_ptr_q <= '0;
        end else if (out_ready && !empty) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule
`default_nettype wire

/* File: src/spd_eeprom.sv */
// Summary of operation
// [R1] sequential read continues after a current or random address read
// [R2] master ack plus more clocks makes device send the next byte
// [R3] master ends a read with no-ack on last byte, then stop
// [R4] address counter advances by one after every byte sent; the code leaves it unchanged for protection select reads
// [R5] counter wraps from the top location back to zero
// [R6] released data line in ninth bit of a read sends device to standby
// [R7] master locks with protection select write plus address and data bytes
// [R8] address and data bytes of the lock command change no stored byte
// [R9] after locking, lower 128 bytes refuse writes; protection code unanswered
// [R10] the lock can never be cleared by any command
// [R11] delivery state: whole array readable and writable, no lock
// [R12] delivery state: every byte reads all ones
// [R13] master should load and check lower half before locking
// [R14] write control input is best held low for full access
// [R15] chip enable pins give slot number; device answers only on match
// [R16] data and clock lines are open drain: pull low or release
// [R17] eighth select bit: one means read, zero means write
// [R18] protection select chip enable bits must match the pins
// [R19] read address counter is eight bits, wrapping naturally
`timescale 1ns/1ps
`default_nettype none
`include "spd_cfg.svh"
module spd_eeprom (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // two-wire bus
    input  wire logic scl_in,
    output logic      scl_out,
    output logic      scl_oe,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // straps
    input  wire logic chip_enable_bit0,
    input  wire logic chip_enable_bit1,
    input  wire logic chip_enable_bit2,
    input  wire logic write_control_input_n,
    // status
    output logic      lower_half_locked,
    output logic      write_busy
);
    import spd_pkg::*;

    // ****************************************
    // pin synchronisation
    // ****************************************

    logic [5:0]    raw_pins;
    logic [5:0]    sync_pins;
    logic          scl_s;
    logic          sda_s;
    logic [2:0]    ce_s;
    logic          wctl_n_s;

    assign raw_pins = {write_control_input_n, chip_enable_bit2, chip_enable_bit1,
                       chip_enable_bit0, sda_in, scl_in};

    spd_sync #(
        .WIDTH (6)
    ) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .d     (raw_pins),
        .q     (sync_pins)
    );

    assign scl_s    = sync_pins[0];
    assign sda_s    = sync_pins[1];
    assign ce_s     = sync_pins[4:2];
    assign wctl_n_s = sync_pins[5];

    // ****************************************
    // bus events
    // ****************************************

    logic          scl_prev_q;
    logic          sda_prev_q;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ****************************************
    // state and decode
    // ****************************************

    spd_state_type state_q;
    logic [2:0]    cnt_q;
    logic [7:0]    shift_q;
    logic          full_q;
    logic          rw_q;
    logic          prot_q;
    logic          ack_seen_q;
    logic          sda_drv_q;
    logic [7:0]    addr_q;
    logic          sw_prot_q;
    logic          got_prot_q;
    logic          wrote_q;
    logic          commit_q;
    logic [7:0]    mem_q [256];

    logic          rx_state;
    logic          byte_done;
    logic          hit_mem;
    logic          hit_prot;
    logic          dev_ack;
    logic          wr_ok;
    logic          data_ack;
    logic          push;
    logic          load_rd;
    logic [7:0]    rd_byte;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic          drain;
    spd_wr_type    fifo_in;
    spd_wr_type    fifo_out;

    // type code and slot number both match
    function automatic logic select_match(input logic [7:0] sel,
                                          input logic [3:0] code,
                                          input logic [2:0] ce);
        select_match = (sel[7:4] == code) && (sel[3:1] == ce);
    endfunction

    assign rx_state  = (state_q == ST_DEV) || (state_q == ST_ADDR) || (state_q == ST_WDATA);
    assign byte_done = rx_state & scl_fall & full_q;
    assign hit_mem   = select_match(shift_q, `SPD_MEM_CODE, ce_s);  // [R15]
    assign hit_prot  = select_match(shift_q, `SPD_PROT_CODE, ce_s) & ~sw_prot_q;  // [R18]
    assign dev_ack   = (hit_mem | hit_prot) & ~commit_q;
    // write control high locks the whole array
    assign wr_ok     = ~wctl_n_s & ~(sw_prot_q & ~addr_q[`SPD_HALF_BIT]) & fifo_in_ready; // [R14]
    assign data_ack  = prot_q ? ~wctl_n_s : wr_ok;
    assign push      = byte_done & (state_q == ST_WDATA) & ~prot_q & wr_ok;
    assign load_rd   = scl_fall & (((state_q == ST_DEV_ACK) & rw_q) |  // [R1]
                                   ((state_q == ST_RACK) & ack_seen_q));  // [R2]
    assign rd_byte   = prot_q ? `SPD_ERASED : mem_q[addr_q];

    // ****************************************
    // bit engine
    // ****************************************

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_q   <= 3'h0;
            shift_q <= 8'h00;
            full_q  <= 1'b0;
        end else if (start_det || (state_q == ST_IDLE)) begin
            cnt_q  <= 3'h0;
            full_q <= 1'b0;
        end else if (load_rd) begin
            shift_q <= rd_byte;
            cnt_q   <= 3'h0;
        end else if ((state_q == ST_RDATA) && scl_fall && (cnt_q != `SPD_LAST_BIT)) begin
            shift_q <= {shift_q[6:0], 1'b0};
            cnt_q   <= cnt_q + 3'h1;
        end else if (rx_state && scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q   <= cnt_q + 3'h1;
            full_q  <= (cnt_q == `SPD_LAST_BIT);
        end else if (byte_done) begin
            full_q <= 1'b0;
        end
    end

    // ****************************************
    // protocol state machine
    // ****************************************

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            rw_q       <= 1'b0;
            prot_q     <= 1'b0;
            ack_seen_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
        end else if (start_det) begin
            state_q <= ST_DEV;
        end else begin
            case (state_q)
                ST_DEV: begin
                    if (byte_done) begin
                        if (dev_ack) begin
                            state_q <= ST_DEV_ACK;
                            rw_q    <= shift_q[`SPD_RW_BIT];  // [R17]
                            prot_q  <= hit_prot;  // [R7]
                        end else begin
                            state_q <= ST_IDLE;  // [R15]
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        state_q <= rw_q ? ST_RDATA : ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        state_q <= ST_ADDR_ACK;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        state_q <= ST_WDATA_ACK;
                    end
                end
                ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall && (cnt_q == `SPD_LAST_BIT)) begin
                        state_q    <= ST_RACK;
                        ack_seen_q <= 1'b0;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_q <= ST_IDLE;  // [R6]
                        end else begin
                            ack_seen_q <= 1'b1;
                        end
                    end else if (load_rd) begin
                        state_q <= ST_RDATA;  // [R2]
                    end
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // data line drive
    // ****************************************

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sda_drv_q <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_drv_q <= 1'b0;
        end else if (byte_done) begin
            if (state_q == ST_DEV) begin
                sda_drv_q <= dev_ack;  // [R9]
            end else if (state_q == ST_ADDR) begin
                sda_drv_q <= 1'b1;
            end else begin
                sda_drv_q <= data_ack;
            end
        end else if (load_rd) begin
            sda_drv_q <= ~rd_byte[7];
        end else if ((state_q == ST_RDATA) && scl_fall) begin
            sda_drv_q <= (cnt_q == `SPD_LAST_BIT) ? 1'b0 : ~shift_q[6];
        end else if (scl_fall) begin
            sda_drv_q <= 1'b0;
        end
    end

    // ****************************************
    // address counter
    // ****************************************

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            addr_q <= 8'h00;
        end else if (byte_done && (state_q == ST_ADDR) && !prot_q) begin
            addr_q <= shift_q;
        end else if (load_rd && !prot_q) begin
            addr_q <= addr_q + `SPD_ADDR_ONE;  // [R4] [R5] [R19]
        end else if (push) begin
            addr_q <= {addr_q[7:4], addr_q[3:0] + `SPD_PAGE_ONE};
        end
    end

    // ****************************************
    // software lock
    // ****************************************

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            got_prot_q <= 1'b0;
        end else if (byte_done && (state_q == ST_WDATA) && prot_q && data_ack) begin
            got_prot_q <= 1'b1;
        end else if (start_det || stop_det) begin
            got_prot_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sw_prot_q <= 1'b0;  // [R11]
        end else if (stop_det && got_prot_q) begin
            sw_prot_q <= 1'b1;  // [R9] [R10]
        end
    end

    // ****************************************
    // write buffer and commit
    // ****************************************

    assign fifo_in.addr = addr_q;
    assign fifo_in.data = shift_q;
    assign drain        = commit_q & fifo_out_valid;

    spd_fifo #(
        .WIDTH (`SPD_FIFO_WIDTH),
        .DEPTH (`SPD_FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (push),  // [R8]
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (commit_q),
        .out_data  (fifo_out)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wrote_q <= 1'b0;
        end else if (push) begin
            wrote_q <= 1'b1;
        end else if (stop_det) begin
            wrote_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            commit_q <= 1'b0;
        end else if (stop_det && wrote_q) begin
            commit_q <= 1'b1;
        end else if (!fifo_out_valid) begin
            commit_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 256; i++) begin
                mem_q[i] <= `SPD_ERASED;  // [R12]
            end
        end else if (drain) begin
            mem_q[fifo_out.addr] <= fifo_out.data;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    assign sda_out           = 1'b0;  // [R16]
    assign sda_oe            = sda_drv_q;
    assign scl_out           = 1'b0;
    assign scl_oe            = 1'b0;
    assign lower_half_locked = sw_prot_q;
    assign write_busy        = commit_q;

    // ****************************************
    // assertions
    // ****************************************

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_addr_step: assert property (load_rd && !prot_q |=> addr_q == $past(addr_q) + 8'h01) // [R4]
        else $error("address counter did not advance after a byte");
    a_addr_wrap: assert property (load_rd && !prot_q && addr_q == 8'hFF |=> addr_q == 8'h00) // [R5]
        else $error("address counter did not wrap to zero");
    a_noack_standby: assert property (state_q == ST_RACK && scl_rise && sda_s // [R6]
        && !stop_det && !start_det |=> state_q == ST_IDLE && !sda_drv_q)
        else $error("no standby after missing acknowledge");
    a_next_byte: assert property (load_rd |=> state_q == ST_RDATA // [R2]
        && shift_q == $past(rd_byte) && sda_drv_q == !$past(rd_byte[7]))
        else $error("next byte not presented after acknowledge");
    a_lock_sticky: assert property (sw_prot_q |=> sw_prot_q) // [R10]
        else $error("lower half lock was cleared");
    a_prot_ignored: assert property (byte_done && state_q == ST_DEV && sw_prot_q // [R9]
        && shift_q[7:4] == 4'h6 |=> !sda_drv_q && state_q == ST_IDLE)
        else $error("protection select answered after lock");
    a_lower_locked: assert property (drain |-> !(sw_prot_q && !fifo_out.addr[7])) // [R9]
        else $error("write reached locked lower half");
    a_prot_no_store: assert property (prot_q && state_q != ST_IDLE |-> !push) // [R8]
        else $error("lock command bytes entered the write buffer");
    a_prot_addr_kept: assert property (prot_q && byte_done && state_q == ST_ADDR // [R8]
        |=> addr_q == $past(addr_q))
        else $error("lock command address byte moved the counter");
    a_ce_mismatch: assert property (byte_done && state_q == ST_DEV // [R15]
        && shift_q[3:1] != ce_s |=> state_q == ST_IDLE && !sda_drv_q)
        else $error("device answered a foreign slot number");

    c_seq_wrap: cover property (load_rd && addr_q == 8'hFF ##[1:400] load_rd);
    c_lock_set: cover property ($rose(sw_prot_q));
    c_commit: cover property (drain ##2 !commit_q);

endmodule
`default_nettype wire

/* File: bench/spd_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module spd_bus_master (
    // clock
    input  wire logic mclk,
    // data line level on the wire
    input  wire logic sda,
    // pull-downs: high pulls the line low
    output logic      scl_low,
    output logic      sda_low
);
    // ******************
    // bus phases
    // ******************
    localparam int QTR = 8;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic gap();
        repeat (QTR) @(negedge mclk);
    endtask

    // start, also serves as repeated start
    task automatic start();
        gap();
        sda_low = 1'b0;
        gap();
        scl_low = 1'b0;
        gap();
        sda_low = 1'b1;
        gap();
        scl_low = 1'b1;
    endtask

    task automatic stop();
        gap();
        sda_low = 1'b1;
        gap();
        scl_low = 1'b0;
        gap();
        sda_low = 1'b0;
        gap();
    endtask

    // a one is sent by releasing the line to its pull-up
    task automatic bit_io(input logic b, output logic got);
        gap();
        sda_low = ~b;
        gap();
        scl_low = 1'b0;
        gap();
        got = sda;
        gap();
        scl_low = 1'b1;
    endtask

    // ack_in low acknowledges; ack_out low means acknowledged
    task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_out);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], b);
            rx[i] = b;
        end
        bit_io(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spd_cfg.svh"
module tb_top;
    import spd_pkg::*;

    localparam logic [2:0] SLOT = 3'h5;

    logic       mclk;
    logic       reset;
    logic       scl;
    logic       sda;
    logic       scl_low;
    logic       sda_low;
    logic       scl_out;
    logic       scl_oe;
    logic       sda_out;
    logic       sda_oe;
    logic [2:0] ce;
    logic       wctl_n;
    logic       locked;
    logic       busy;
    int         miscompares;
    int         n_tests;

    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    // open drain lines with pull-ups
    assign scl = ~(scl_low | (scl_oe & ~scl_out));
    assign sda = ~(sda_low | (sda_oe & ~sda_out));

    spd_eeprom u_dut (
        .mclk                  (mclk),
        .reset                 (reset),
        .scl_in                (scl),
        .scl_out               (scl_out),
        .scl_oe                (scl_oe),
        .sda_in                (sda),
        .sda_out               (sda_out),
        .sda_oe                (sda_oe),
        .chip_enable_bit0      (ce[0]),
        .chip_enable_bit1      (ce[1]),
        .chip_enable_bit2      (ce[2]),
        .write_control_input_n (wctl_n),
        .lower_half_locked     (locked),
        .write_busy            (busy)
    );

    spd_bus_master u_master (
        .mclk    (mclk),
        .sda     (sda),
        .scl_low (scl_low),
        .sda_low (sda_low)
    );

    // ******************
    // checking
    // ******************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // ******************
    // bus helpers
    // ******************
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0) begin
            @(negedge mclk);
            n++;
            if (n > 4000) begin
                miscompares++;
                $display("mismatch at %0t: write cycle never ended", $time);
                complete_run();
            end
        end
    endtask

    task automatic sel(input logic [3:0] code, input logic [2:0] c, input logic rw,
                       output logic ack);
        logic [7:0] rx;
        u_master.byte_io({code, c, rw}, 1'b1, rx, ack);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic dack);
        logic       ack;
        logic [7:0] rx;
        u_master.start();
        sel(`SPD_MEM_CODE, SLOT, 1'b0, ack);
        u_master.byte_io(a, 1'b1, rx, ack);
        u_master.byte_io(d, 1'b1, rx, dack);
        u_master.stop();
        wait_idle();
    endtask

    task automatic lock_cmd(output logic dack);
        logic       ack;
        logic [7:0] rx;
        u_master.start();
        sel(`SPD_PROT_CODE, SLOT, 1'b0, ack);
        u_master.byte_io(8'h10, 1'b1, rx, ack);
        u_master.byte_io(8'h00, 1'b1, rx, dack);
        u_master.stop();
        wait_idle();
    endtask

    task automatic open_rd(input logic [7:0] a);
        logic       ack;
        logic [7:0] rx;
        u_master.start();
        sel(`SPD_MEM_CODE, SLOT, 1'b0, ack);
        u_master.byte_io(a, 1'b1, rx, ack);
        u_master.start();
        sel(`SPD_MEM_CODE, SLOT, 1'b1, ack);
        chk1(ack, 1'b0, "read select ack");
    endtask

    task automatic rd_next(input logic [7:0] exp, input logic last);
        logic [7:0] rx;
        logic       a;
        u_master.byte_io(8'hFF, last, rx, a);
        chk8(rx, exp, "read data");
    endtask

    task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
        open_rd(a);
        rd_next(exp, 1'b1);
        u_master.stop();
    endtask

    // ******************
    // scenarios
    // ******************
    task automatic test_delivery();
        chk1(locked, 1'b0, "lock at delivery");
        open_rd(8'h7E);
        rd_next(8'hFF, 1'b0);
        rd_next(8'hFF, 1'b0);
        rd_next(8'hFF, 1'b1);
        chk1(scl_oe, 1'b0, "clock line pulled");
        chk1(sda_out, 1'b0, "data line driven high");
        u_master.stop();
        $display("test delivery done");
    endtask

    task automatic test_wrap();
        logic d;
        logic b;
        wr(8'hFF, 8'h5A, d);
        chk1(d, 1'b0, "data ack");
        wr(8'h00, 8'hA5, d);
        wr(8'h02, 8'hC3, d);
        open_rd(8'hFE);
        rd_next(8'hFF, 1'b0);
        rd_next(8'h5A, 1'b0);
        rd_next(8'hA5, 1'b0);
        rd_next(8'hFF, 1'b1);
        u_master.bit_io(1'b1, b);
        chk1(b, 1'b1, "line released after no ack");
        u_master.stop();
        u_master.start();
        sel(`SPD_MEM_CODE, SLOT, 1'b1, b);
        rd_next(8'hC3, 1'b1);
        u_master.stop();
        $display("test wrap done");
    endtask

    task automatic test_page();
        logic       a;
        logic [7:0] rx;
        u_master.start();
        sel(`SPD_MEM_CODE, SLOT, 1'b0, a);
        u_master.byte_io(8'hA0, 1'b1, rx, a);
        for (int i = 0; i < 17; i++) begin
            u_master.byte_io({4'hC, 4'(i)}, 1'b1, rx, a);
            chk1(a, (i < 16) ? 1'b0 : 1'b1, "page byte ack");
        end
        u_master.stop();
        chk1(busy, 1'b1, "page commit busy");
        wait_idle();
        open_rd(8'hA0);
        for (int i = 0; i < 16; i++) begin
            rd_next({4'hC, 4'(i)}, (i == 15));
        end
        u_master.stop();
        $display("test page done");
    endtask

    task automatic test_slots();
        logic a;
        for (int c = 0; c < 8; c++) begin
            u_master.start();
            sel(`SPD_MEM_CODE, 3'(c), 1'b1, a);
            chk1(a, (3'(c) == SLOT) ? 1'b0 : 1'b1, "slot ack");
            if (a === 1'b0) begin
                rd_next(8'hFF, 1'b1);
            end
            u_master.stop();
        end
        $display("test slots done");
    endtask

    task automatic test_wr_ctl();
        logic d;
        wctl_n = 1'b1;
        wr(8'h20, 8'h33, d);
        chk1(d, 1'b1, "data refused under write control");
        lock_cmd(d);
        chk1(d, 1'b1, "lock refused under write control");
        chk1(locked, 1'b0, "no lock under write control");
        wctl_n = 1'b0;
        rd1(8'h20, 8'hFF);
        $display("test write control done");
    endtask

    task automatic test_lock();
        logic d;
        logic a;
        wr(8'h10, 8'h3C, d);
        lock_cmd(d);
        chk1(d, 1'b0, "lock data ack");
        chk1(locked, 1'b1, "locked");
        rd1(8'h10, 8'h3C);
        for (int rw = 0; rw < 2; rw++) begin
            u_master.start();
            sel(`SPD_PROT_CODE, SLOT, 1'(rw), a);
            chk1(a, 1'b1, "protection select after lock");
            u_master.stop();
        end
        wr(8'h10, 8'h99, d);
        chk1(d, 1'b1, "lower half write refused");
        wr(8'h90, 8'h77, d);
        chk1(d, 1'b0, "upper half write");
        rd1(8'h90, 8'h77);
        rd1(8'h10, 8'h3C);
        chk1(locked, 1'b1, "still locked");
        $display("test lock done");
    endtask

    initial begin
        reset = 1'b1;
        wctl_n = 1'b0;
        ce = SLOT;
        miscompares = 0;
        n_tests = 0;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        test_delivery();
        test_wrap();
        test_page();
        test_slots();
        test_wr_ctl();
        test_lock();
        complete_run();
    end
endmodule
`default_nettype wire
